// *** rtl/pwmcr_pkg.sv ***
// Package: offsets, field layouts, reset values and state types of the PWM control slice
package pwmcr_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] PWMCR_IRQ_CLR_OFS  = 12'h308;
  localparam logic [11:0] PWMCR_ENABLE_OFS   = 12'h500;
  localparam logic [11:0] PWMCR_MODE_OFS     = 12'h504;
  localparam logic [11:0] PWMCR_CEIL_OFS     = 12'h508;
  localparam logic [11:0] PWMCR_PRESC_OFS    = 12'h50C;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int          PWMCR_NUM_EVT      = 7;
  localparam int          PWMCR_EVT_LSB      = 1;
  localparam int          PWMCR_EVT_HALT     = 0;
  localparam int          PWMCR_EVT_BEGUN0   = 1;
  localparam int          PWMCR_EVT_FIN0     = 3;
  localparam int          PWMCR_EVT_PERIOD   = 5;
  localparam int          PWMCR_EVT_LOOPS    = 6;
  localparam int          PWMCR_CEIL_W       = 15;
  localparam int          PWMCR_PRESC_W      = 3;
  localparam int          PWMCR_DIVCNT_W     = 7;
  localparam logic [6:0]  PWMCR_IRQ_EN_RST   = 7'h00;
  localparam logic        PWMCR_ENABLE_RST   = 1'b0;
  localparam logic        PWMCR_MODE_RST     = 1'b0;
  localparam logic [14:0] PWMCR_CEIL_RST     = 15'h03FF;
  localparam logic [2:0]  PWMCR_PRESC_RST    = 3'h0;
  localparam logic [6:0]  PWMCR_DIVCNT_RST   = 7'h00;
  localparam logic [31:0] PWMCR_RDATA_RST    = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Decoder load settings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PWMCR_LOAD_COMMON     = 2'b00,
    PWMCR_LOAD_GROUPED    = 2'b01,
    PWMCR_LOAD_INDIVIDUAL = 2'b10,
    PWMCR_LOAD_WAVEFORM   = 2'b11
  } pwmcr_load_t;

  // ----------------------------------------------------------------
  // Module state records
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [6:0]  irq_en;
    logic        en;
    logic        mode;
    logic [14:0] ceil;
    logic [2:0]  presc;
    logic [31:0] rdata;
  } pwmcr_regs_t;

  typedef struct packed {
    logic [6:0]  cnt;
    logic        tick;
  } pwmcr_div_t;

  typedef struct packed {
    logic [15:0] cmp0;
    logic [15:0] cmp1;
    logic [15:0] cmp2;
    logic [14:0] eff_ceil;
  } pwmcr_sel_t;
endpackage : pwmcr_pkg

// *** rtl/pwmcr_div.sv ***
// Prescaler: divides the base-rate tick by a power of two into the modulation tick
`timescale 1ns/1ps
module pwmcr_div
  import pwmcr_pkg::*;
(
  input  wire logic       clk_i,       // System clock
  input  wire logic       rst_i,       // Synchronous reset, active high
  input  wire logic       en_i,        // Unit enabled
  input  wire logic [2:0] code_i,      // Divide code, 2**code
  input  wire logic       base_tick_i, // Base-rate tick, one cycle
  output logic            pwm_tick_o   // Modulation tick, one cycle
);
  pwmcr_div_t state_ff;
  pwmcr_div_t nxt_state;
  logic [6:0] div_mask;

  assign div_mask = 7'((8'h01 << code_i) - 8'h01);

  always_comb begin
    nxt_state      = state_ff;
    nxt_state.tick = 1'b0;
    if (!en_i) begin
      // Restart cleanly so the first tick after enabling has full length
      nxt_state.cnt = PWMCR_DIVCNT_RST;
    end else if (base_tick_i) begin
      if ((state_ff.cnt & div_mask) == div_mask) begin
        nxt_state.cnt  = PWMCR_DIVCNT_RST;
        nxt_state.tick = 1'b1;
      end else begin
        nxt_state.cnt = state_ff.cnt + 7'h01;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= '{cnt: PWMCR_DIVCNT_RST, tick: 1'b0};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign pwm_tick_o = state_ff.tick;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  div1_pass_a: assert property (en_i && base_tick_i && code_i == 3'h0 |=> pwm_tick_o)
    else $error("divide by one did not pass the base tick");
  tick_cause_a: assert property (pwm_tick_o |-> $past(base_tick_i) && $past(en_i))
    else $error("modulation tick without a base tick");
  div2_skip_a: assert property (en_i && base_tick_i && code_i == 3'h1 && pwm_tick_o
                                |=> !pwm_tick_o)
    else $error("divide by two ticked twice in a row");
endmodule : pwmcr_div

// *** rtl/pwmcr_sel.sv ***
// Ceiling selection and waveform-group unpacking for the pulse counter
`timescale 1ns/1ps
module pwmcr_sel
  import pwmcr_pkg::*;
(
  input  wire logic        clk_i,      // System clock
  input  wire logic        rst_i,      // Synchronous reset, active high
  input  wire logic [1:0]  load_i,     // Decoder load setting
  input  wire logic        grp_vld_i,  // Fetched group valid, one cycle
  input  wire logic [63:0] grp_data_i, // Four half-words, first in low bits
  input  wire logic [14:0] reg_ceil_i, // Programmed ceiling
  output logic [15:0]      cmp0_o,     // Channel 0 compare
  output logic [15:0]      cmp1_o,     // Channel 1 compare
  output logic [15:0]      cmp2_o,     // Channel 2 compare
  output logic [14:0]      ceil_o      // Ceiling in force
);
  pwmcr_sel_t state_ff;
  pwmcr_sel_t nxt_state;
  logic       wave;

  assign wave = (load_i == PWMCR_LOAD_WAVEFORM);

  always_comb begin
    nxt_state = state_ff;
    if (wave) begin
      if (grp_vld_i) begin
        nxt_state.cmp0     = grp_data_i[15:0];
        nxt_state.cmp1     = grp_data_i[31:16];
        nxt_state.cmp2     = grp_data_i[47:32];
        nxt_state.eff_ceil = grp_data_i[62:48];
      end
      // Programmed value is not looked at here, only fetched ones
    end else begin
      nxt_state.eff_ceil = reg_ceil_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= '{cmp0: 16'h0000, cmp1: 16'h0000, cmp2: 16'h0000,
                    eff_ceil: PWMCR_CEIL_RST};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign cmp0_o = state_ff.cmp0;
  assign cmp1_o = state_ff.cmp1;
  assign cmp2_o = state_ff.cmp2;
  assign ceil_o = state_ff.eff_ceil;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  wave_hold_a: assert property (wave && !grp_vld_i |=> $stable(ceil_o))
    else $error("ceiling moved in waveform setting without a fetch");
  wave_ceil_a: assert property (wave && grp_vld_i |=> ceil_o == $past(grp_data_i[62:48]))
    else $error("ceiling not taken from the fourth half-word");
  wave_ch_a: assert property (wave && grp_vld_i
                              |=> cmp2_o == $past(grp_data_i[47:32])
                                  && cmp1_o == $past(grp_data_i[31:16])
                                  && cmp0_o == $past(grp_data_i[15:0]))
    else $error("channel compares not taken from the group");
  reg_ceil_a: assert property (!wave |=> ceil_o == $past(reg_ceil_i))
    else $error("programmed ceiling not used outside waveform setting");
  wave_load_c: cover property (wave && grp_vld_i);
endmodule : pwmcr_sel

// *** rtl/pwmcr_regs.sv ***
// PWM control register slice: event interrupt enables, enable, mode, ceiling, prescaler
`timescale 1ns/1ps
module pwmcr_regs
  import pwmcr_pkg::*;
(
  input  wire logic        clk_i,       // System clock, 50 MHz
  input  wire logic        rst_i,       // Synchronous reset, active high
  input  wire logic [11:0] addr_i,      // Register byte address
  input  wire logic [31:0] wdata_i,     // Write data
  input  wire logic        wr_i,        // Write strobe, one cycle
  input  wire logic        rd_i,        // Read strobe, one cycle
  output logic [31:0]      rdata_o,     // Read data, cycle after strobe
  input  wire logic [6:0]  irq_set_i,   // Enable-set pulses per event
  input  wire logic        base_tick_i, // Base-rate tick, one cycle
  input  wire logic [1:0]  load_i,      // Decoder load setting
  input  wire logic        grp_vld_i,   // Fetched group valid
  input  wire logic [63:0] grp_data_i,  // Fetched group, four half-words
  output logic [6:0]       irq_en_o,    // Event interrupt enables
  output logic             unit_en_o,   // Unit enabled
  output logic             mode_o,      // Wave counter mode
  output logic             pwm_tick_o,  // Modulation clock tick
  output logic [15:0]      cmp0_o,      // Channel 0 compare
  output logic [15:0]      cmp1_o,      // Channel 1 compare
  output logic [15:0]      cmp2_o,      // Channel 2 compare
  output logic [14:0]      ceil_o,      // Ceiling in force
  output logic [6:0]       count_o      // Pulse counter
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  pwmcr_regs_t state_ff;
  pwmcr_regs_t nxt_state;
  logic [6:0]  irq_clr;
  logic [14:0] cnt_ff;
  logic [14:0] nxt_cnt;

  assign irq_clr = (wr_i && addr_i == PWMCR_IRQ_CLR_OFS) ?
                   wdata_i[PWMCR_EVT_LSB +: PWMCR_NUM_EVT] : 7'h00;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state       = state_ff;
    nxt_state.rdata = PWMCR_RDATA_RST;
    // Hardware set beats a simultaneous clear so no enable request is lost
    nxt_state.irq_en = (state_ff.irq_en & ~irq_clr) | irq_set_i;
    if (wr_i) begin
      case (addr_i)
        PWMCR_ENABLE_OFS: nxt_state.en    = wdata_i[0];
        PWMCR_MODE_OFS:   nxt_state.mode  = wdata_i[0];
        PWMCR_CEIL_OFS:   nxt_state.ceil  = wdata_i[PWMCR_CEIL_W-1:0];
        PWMCR_PRESC_OFS:  nxt_state.presc = wdata_i[PWMCR_PRESC_W-1:0];
        default:          nxt_state.en    = nxt_state.en;
      endcase
    end
    if (rd_i) begin
      case (addr_i)
        PWMCR_IRQ_CLR_OFS:
          nxt_state.rdata[PWMCR_EVT_LSB +: PWMCR_NUM_EVT] = state_ff.irq_en;
        PWMCR_ENABLE_OFS: nxt_state.rdata[0]                 = state_ff.en;
        PWMCR_MODE_OFS:   nxt_state.rdata[0]                 = state_ff.mode;
        PWMCR_CEIL_OFS:   nxt_state.rdata[PWMCR_CEIL_W-1:0]  = state_ff.ceil;
        PWMCR_PRESC_OFS:  nxt_state.rdata[PWMCR_PRESC_W-1:0] = state_ff.presc;
        default:          nxt_state.rdata                    = PWMCR_RDATA_RST;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= '{irq_en: PWMCR_IRQ_EN_RST, en: PWMCR_ENABLE_RST,
                    mode: PWMCR_MODE_RST, ceil: PWMCR_CEIL_RST,
                    presc: PWMCR_PRESC_RST, rdata: PWMCR_RDATA_RST};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign rdata_o   = state_ff.rdata;
  assign irq_en_o  = state_ff.irq_en;
  assign unit_en_o = state_ff.en;
  assign mode_o    = state_ff.mode;

  // ----------------------------------------------------------------
  // Clock division and ceiling selection
  // ----------------------------------------------------------------
  pwmcr_div u_div (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .en_i        (state_ff.en),
    .code_i      (state_ff.presc),
    .base_tick_i (base_tick_i),
    .pwm_tick_o  (pwm_tick_o)
  );

  pwmcr_sel u_sel (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .load_i     (load_i),
    .grp_vld_i  (grp_vld_i),
    .grp_data_i (grp_data_i),
    .reg_ceil_i (state_ff.ceil),
    .cmp0_o     (cmp0_o),
    .cmp1_o     (cmp1_o),
    .cmp2_o     (cmp2_o),
    .ceil_o     (ceil_o)
  );

  // ----------------------------------------------------------------
  // Pulse counter
  // ----------------------------------------------------------------
  // Counts modulation ticks up to the ceiling in force, then wraps
  always_comb begin
    nxt_cnt = cnt_ff;
    if (!state_ff.en) begin
      nxt_cnt = 15'h0000;
    end else if (pwm_tick_o) begin
      nxt_cnt = (cnt_ff >= ceil_o) ? 15'h0000 : cnt_ff + 15'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= 15'h0000;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign count_o = cnt_ff[6:0];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  irq_clear_a: assert property (wr_i && addr_i == PWMCR_IRQ_CLR_OFS && wdata_i[1]
                                && !irq_set_i[0] |=> !irq_en_o[0])
    else $error("halt enable not cleared by write of one");
  irq_keep_a: assert property (wr_i && addr_i == PWMCR_IRQ_CLR_OFS && !wdata_i[7]
                               && !irq_set_i[6] |=> irq_en_o[6] == $past(irq_en_o[6]))
    else $error("zero write changed an event enable");
  irq_set_wins_a: assert property (irq_set_i[3] |=> irq_en_o[3])
    else $error("enable set lost against clear");
  irq_rd_begun_a: assert property (rd_i && addr_i == PWMCR_IRQ_CLR_OFS
                                   |=> rdata_o[3:1] == $past(irq_en_o[2:0])
                                       && rdata_o[0] == 1'b0)
    else $error("halt or sequence-begun enables misread");
  irq_rd_fin_a: assert property (rd_i && addr_i == PWMCR_IRQ_CLR_OFS
                                 |=> rdata_o[7:4] == $past(irq_en_o[6:3])
                                     && rdata_o[31:8] == 24'h000000)
    else $error("finished, period or loops enables misread");
  en_reset_a: assert property ($fell(rst_i) |-> !unit_en_o && ceil_o == PWMCR_CEIL_RST)
    else $error("unit not off or ceiling wrong after reset");
  en_write_a: assert property (wr_i && addr_i == PWMCR_ENABLE_OFS
                               |=> unit_en_o == $past(wdata_i[0]))
    else $error("enable write not taken");
  mode_write_a: assert property (wr_i && addr_i == PWMCR_MODE_OFS
                                 |=> mode_o == $past(wdata_i[0]))
    else $error("mode write not taken");
  ceil_rd_a: assert property (wr_i && addr_i == PWMCR_CEIL_OFS ##1 rd_i && addr_i == PWMCR_CEIL_OFS
                              |=> rdata_o[14:0] == $past(wdata_i[14:0], 2))
    else $error("ceiling readback wrong");
  cnt_bound_a: assert property (unit_en_o && pwm_tick_o && cnt_ff >= ceil_o
                                |=> cnt_ff == 15'h0000)
    else $error("counter did not wrap at ceiling");
  presc_rd_a: assert property (wr_i && addr_i == PWMCR_PRESC_OFS ##1 rd_i
                               && addr_i == PWMCR_PRESC_OFS
                               |=> rdata_o[2:0] == $past(wdata_i[2:0], 2))
    else $error("prescaler readback wrong");
  rd_once_a: assert property (!rd_i |=> rdata_o == 32'h0000_0000)
    else $error("read data stands beyond its cycle");

  // Decoded only for checking; the register file decodes per case item
  logic addr_mapped;
  assign addr_mapped = (addr_i == PWMCR_IRQ_CLR_OFS) || (addr_i == PWMCR_ENABLE_OFS)
                    || (addr_i == PWMCR_MODE_OFS) || (addr_i == PWMCR_CEIL_OFS)
                    || (addr_i == PWMCR_PRESC_OFS);

  unmapped_rd_a: assert property (rd_i && !addr_mapped
                                  |=> rdata_o == PWMCR_RDATA_RST)
    else $error("read of an unmapped place returned data");
  unmapped_wr_a: assert property (wr_i && !addr_mapped
                                  |=> $stable(state_ff.en) && $stable(state_ff.mode)
                                      && $stable(state_ff.ceil) && $stable(state_ff.presc))
    else $error("write to an unmapped place changed a register");
  en_rd_a: assert property (rd_i && addr_i == PWMCR_ENABLE_OFS
                            |=> rdata_o == {31'h0000_0000, $past(unit_en_o)})
    else $error("enable misread");
  mode_rd_a: assert property (rd_i && addr_i == PWMCR_MODE_OFS
                              |=> rdata_o == {31'h0000_0000, $past(mode_o)})
    else $error("mode misread");
  ceil_upper_a: assert property (rd_i && addr_i == PWMCR_CEIL_OFS
                                 |=> rdata_o[31:15] == 17'h00000)
    else $error("bits above the ceiling field read nonzero");
  presc_upper_a: assert property (rd_i && addr_i == PWMCR_PRESC_OFS
                                  |=> rdata_o[31:3] == 29'h00000000)
    else $error("bits above the prescaler field read nonzero");
  ceil_write_a: assert property (wr_i && addr_i == PWMCR_CEIL_OFS
                                 |=> state_ff.ceil == $past(wdata_i[14:0]))
    else $error("ceiling write not taken");
  presc_write_a: assert property (wr_i && addr_i == PWMCR_PRESC_OFS
                                  |=> state_ff.presc == $past(wdata_i[2:0]))
    else $error("prescaler write not taken");
  ceil_hold_a: assert property (!(wr_i && addr_i == PWMCR_CEIL_OFS)
                                |=> $stable(state_ff.ceil))
    else $error("ceiling changed without a write");
  en_hold_a: assert property (!(wr_i && addr_i == PWMCR_ENABLE_OFS)
                              |=> $stable(unit_en_o))
    else $error("enable changed without a write");
  off_clear_a: assert property (!unit_en_o |=> cnt_ff == 15'h0000)
    else $error("counter not cleared while disabled");
  off_quiet_a: assert property (!unit_en_o |=> !pwm_tick_o)
    else $error("modulation tick while disabled");
  cnt_step_a: assert property (unit_en_o && pwm_tick_o && cnt_ff < ceil_o
                               |=> cnt_ff == $past(cnt_ff) + 15'h0001)
    else $error("counter did not step by one");
  cnt_idle_a: assert property (unit_en_o && !pwm_tick_o |=> $stable(cnt_ff))
    else $error("counter moved without a tick");

  // ----------------------------------------------------------------
  // Per-event enable checks
  // ----------------------------------------------------------------
  // One copy per event so a slip between bit positions shows up
  for (genvar g = 0; g < PWMCR_NUM_EVT; g++) begin : g_evt
    evt_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
                                  irq_clr[g] && !irq_set_i[g] |=> !irq_en_o[g])
      else $error("event enable not cleared by write of one");
    evt_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
                                 !irq_clr[g] && !irq_set_i[g]
                                 |=> irq_en_o[g] == $past(irq_en_o[g]))
      else $error("event enable changed without set or clear");
    evt_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
                                irq_set_i[g] |=> irq_en_o[g])
      else $error("event enable not set by its pulse");
    evt_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
                                 rd_i && addr_i == PWMCR_IRQ_CLR_OFS
                                 |=> rdata_o[PWMCR_EVT_LSB + g] == $past(irq_en_o[g]))
      else $error("event enable misread");
  end : g_evt

  irq_clear_c: cover property (wr_i && addr_i == PWMCR_IRQ_CLR_OFS && |irq_en_o);
  wrap_c:      cover property (unit_en_o && pwm_tick_o && cnt_ff >= ceil_o);
  div128_c:    cover property (unit_en_o && state_ff.presc == 3'h7 && pwm_tick_o);
endmodule : pwmcr_regs

// *** verif/tb.sv ***
// Self-checking testbench for the PWM control register slice
`timescale 1ns/1ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module tb;
  import pwmcr_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [11:0] addr_i = 12'h000;
  logic [31:0] wdata_i = 32'h0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic [6:0]  irq_set_i = 7'h00;
  logic        base_tick_i = 1'b0;
  logic [1:0]  load_i = 2'h0;
  logic        grp_vld_i = 1'b0;
  logic [63:0] grp_data_i = 64'h0;
  logic [6:0]  irq_en_o;
  logic        unit_en_o;
  logic        mode_o;
  logic        pwm_tick_o;
  logic [15:0] cmp0_o, cmp1_o, cmp2_o;
  logic [14:0] ceil_o;
  logic [6:0]  count_o;
  int          n_errors = 0;
  int          n_checks = 0;
  int          cycles = 0;
  logic [31:0] seed = 32'd35399;

  pwmcr_regs pwmcr_regs_inst (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .irq_set_i(irq_set_i), .base_tick_i(base_tick_i), .load_i(load_i),
    .grp_vld_i(grp_vld_i), .grp_data_i(grp_data_i), .irq_en_o(irq_en_o),
    .unit_en_o(unit_en_o), .mode_o(mode_o), .pwm_tick_o(pwm_tick_o), .cmp0_o(cmp0_o),
    .cmp1_o(cmp1_o), .cmp2_o(cmp2_o), .ceil_o(ceil_o), .count_o(count_o));

  always #10 clk_i = ~clk_i;

  // ----------------------------------------------------------------
  // Bus tasks and helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic bus_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
    #1;
  endtask : bus_wr

  // Read data stand only in the cycle after the strobe, so they are taken there
  task automatic bus_rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1;
    d = rdata_o;
  endtask : bus_rd

  // Write then read the same place with no gap, as the bus allows
  task automatic bus_wr_rd(input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
    rd_i    <= 1'b1;
    @(posedge clk_i);
    rd_i    <= 1'b0;
    #1;
    q = rdata_o;
  endtask : bus_wr_rd

  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  // Timeout well above the roughly 2400 cycles the sequence needs
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  logic [31:0] d, r, m;
  logic [6:0]  en_model;
  logic [11:0] ofs[4] = '{12'h500, 12'h504, 12'h508, 12'h50C};
  logic [31:0] msk[4] = '{32'h1, 32'h1, 32'h7FFF, 32'h7};
  logic [31:0] ticks;
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    `CHK(ceil_o, 15'h03FF)
    `CHK(unit_en_o, 1'b0)
    for (int i = 0; i < 4; i++) begin
      bus_rd(ofs[i], r);
      `CHK(r, (i == 2) ? 32'h0000_03FF : 32'h0)
    end
    bus_rd(12'h308, r);
    `CHK(r, 32'h0)
    // Interrupt enables: set all, then clear with random and single-bit masks
    @(posedge clk_i);
    irq_set_i <= 7'h7F;
    @(posedge clk_i);
    irq_set_i <= 7'h00;
    #1;
    en_model = 7'h7F;
    bus_rd(12'h308, r);
    `CHK(r, 32'h0000_00FE)
    for (int i = 0; i < 7; i++) begin
      bus_wr(12'h308, 32'h1 << (i + 1));
      en_model[i] = 1'b0;
      `CHK(irq_en_o, en_model)
    end
    for (int i = 0; i < 12; i++) begin
      m = rnd();
      @(posedge clk_i);
      irq_set_i <= m[6:0];
      @(posedge clk_i);
      irq_set_i <= 7'h00;
      #1;
      en_model = en_model | m[6:0];
      m = (i == 0) ? 32'hFFFF_FF01 : rnd();
      bus_wr(12'h308, m);
      en_model = en_model & ~m[7:1];
      `CHK(irq_en_o, en_model)
      bus_rd(12'h308, r);
      `CHK(r, {24'h0, en_model, 1'b0})
    end
    // Field widths and read-back of the plain registers; unmapped place ignored
    for (int k = 0; k < 16; k++) begin
      d = rnd();
      bus_wr_rd(ofs[k % 4], d, r);
      `CHK(r, d & msk[k % 4])
      bus_wr_rd(12'h514, rnd(), r);
      `CHK(r, 32'h0)
    end
    bus_rd(12'h504, r);
    `CHK(mode_o, r[0])
    bus_rd(12'h500, r);
    `CHK(unit_en_o, r[0])
    // Prescaler: every divide code, base tick in each cycle
    for (int c = 0; c < 8; c++) begin
      bus_wr(12'h500, 32'h0);
      bus_wr(12'h50C, c);
      if (c == 0) begin
        ticks = 0;
        for (int i = 0; i < 40; i++) begin
          @(posedge clk_i);
          base_tick_i <= (i < 32);
          #1;
          ticks += pwm_tick_o;
        end
        `CHK(ticks, 0)
      end
      bus_wr(12'h500, 32'h1);
      ticks = 0;
      for (int i = 0; i < 260; i++) begin
        @(posedge clk_i);
        base_tick_i <= (i < 256);
        #1;
        ticks += pwm_tick_o;
      end
      `CHK(ticks, 256 >> c)
    end
    // Counter wraps after reaching a small ceiling
    bus_wr(12'h500, 32'h0);
    bus_wr(12'h50C, 32'h0);
    bus_wr(12'h508, 32'h5);
    bus_wr(12'h500, 32'h1);
    for (int i = 0; i < 20; i++) begin
      @(posedge clk_i);
      base_tick_i <= (i < 17);
    end
    #1;
    `CHK(count_o, 7'd5)
    // Waveform setting: groups unpack, programmed ceiling ignored
    @(posedge clk_i);
    load_i <= 2'h3;
    for (int i = 0; i < 4; i++) begin
      d = rnd();
      @(posedge clk_i);
      grp_vld_i  <= 1'b1;
      grp_data_i <= {rnd(), d};
      @(posedge clk_i);
      grp_vld_i  <= 1'b0;
      #1;
      `CHK(cmp0_o, grp_data_i[15:0])
      `CHK(cmp1_o, grp_data_i[31:16])
      `CHK(cmp2_o, grp_data_i[47:32])
      `CHK(ceil_o, grp_data_i[62:48])
    end
    bus_wr(12'h508, 32'h20);
    repeat (2) @(posedge clk_i);
    #1;
    `CHK(ceil_o, grp_data_i[62:48])
    m = {16'h0, grp_data_i[15:0]};
    @(posedge clk_i);
    load_i     <= 2'h1;
    grp_vld_i  <= 1'b1;
    grp_data_i <= ~grp_data_i;
    @(posedge clk_i);
    grp_vld_i  <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    `CHK(ceil_o, 15'h0020)
    `CHK(cmp0_o, m[15:0])
    conclude();
  end
endmodule : tb
